// ---- bench/dimcg_dimm_model.sv ----
// Far-side model: free-running memory clock and downstream scheduler.
// Assumes normal_req is pclk-synchronous; slow picks a long completion.
`timescale 1ns/1ps
module dimcg_dimm_model (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic slow,
    input  wire logic normal_req,
    output logic      normal_done,
    output logic      ddr_clk_in
);
    int wait_cnt;
    // Memory clock runs free, phase unrelated to pclk
    initial begin
        ddr_clk_in = 1'b0;
        #37;
        forever #160 ddr_clk_in = ~ddr_clk_in;
    end
    // One done pulse per request; sentinel stops a second pulse while req lingers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            normal_done <= 1'b0;
            wait_cnt <= 0;
        end else begin
            normal_done <= 1'b0;
            if (!normal_req) begin
                wait_cnt <= 0;
            end else if (wait_cnt >= (slow ? 7 : 1) && wait_cnt < 100) begin
                normal_done <= 1'b1;
                wait_cnt <= 100;
            end else if (wait_cnt < 100) begin
                wait_cnt <= wait_cnt + 1;
            end
        end
    end
endmodule

// ---- bench/tb_top.sv ----
// Self-checking bench: APB master, host driver, command monitor.
// Assumes the far-side model supplies the memory clock and normal_done.
`timescale 1ns/1ps
module tb_top;
    import dimcg_pkg::*;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic        host_req = 0, slow = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [15:0] host_address_lines = '0;
    logic [31:0] prdata;
    logic        pready, pslverr, host_ack, normal_req, normal_done, ddr_clk_in;
    logic        mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n;
    logic [1:0]  mem_bank;
    logic [12:0] memory_address_bus;
    logic [3:0]  ck_ch0, ck_ch0_n, ck_ch1, ck_ch1_n, prev_cmd;
    logic [37:0] q[$];
    logic [37:0] en;
    int          mismatches = 0, num_checks = 0;
    wire  [3:0]  cmd = {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n};

    // Shortened 64 us counts keep the run brief
    dimcg_top #(.REF64_LO(14'h064), .REF64_HI(14'h085)) dimcg_top_inst (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .host_req(host_req), .host_address_lines(host_address_lines), .host_ack(host_ack),
        .normal_req(normal_req), .normal_done(normal_done), .ddr_clk_in(ddr_clk_in),
        .mem_cs_n(mem_cs_n), .mem_ras_n(mem_ras_n), .mem_cas_n(mem_cas_n), .mem_we_n(mem_we_n),
        .mem_bank(mem_bank), .memory_address_bus(memory_address_bus), .ck_ch0(ck_ch0),
        .ck_ch0_n(ck_ch0_n), .ck_ch1(ck_ch1), .ck_ch1_n(ck_ch1_n)
    );
    dimcg_dimm_model dimcg_dimm_model_inst (
        .pclk(pclk), .presetn(presetn), .slow(slow), .normal_req(normal_req),
        .normal_done(normal_done), .ddr_clk_in(ddr_clk_in)
    );

    always #20 pclk = ~pclk;

    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        num_checks++;
        if (got !== ex) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Expected command, with don't-care fields masked off
    task automatic note(input logic [18:0] ex, input logic [18:0] m);
        q.push_back({ex & m, m});
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        for (n = 0; n < 50; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        r = prdata;
        e = pslverr;
        psel <= 0; penable <= 0;
        if (n == 50) chk("pready", 1, 0);
        @(posedge pclk); // Idle edge, so a following call never reassigns psel in this step
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r; logic e;
        apb(1, a, d, r, e);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] ex, input string nm);
        logic [31:0] r; logic e;
        apb(0, a, 0, r, e);
        chk(nm, ex, r);
    endtask
    // Host holds its request until it sees the ack, then drops at once
    task automatic host(input logic [15:0] a, output logic fwd);
        int n;
        fwd = 0;
        host_req <= 1; host_address_lines <= a;
        for (n = 0; n < 200; n++) begin
            @(posedge pclk);
            if (normal_req === 1'b1) fwd = 1;
            if (host_ack === 1'b1) break;
        end
        host_req <= 0;
        if (n == 200) chk("host ack", 1, 0);
    endtask
    function automatic logic [31:0] mc(logic i, logic dl, logic [2:0] rt, logic [2:0] s);
        return {2'b0, i, 6'b0, dl, 2'b0, 1'b0, dl, 2'b0, 5'b0, rt, 1'b0, s, MCTL_LOW_RSV};
    endfunction

    // Each new command off the idle level takes the oldest note
    always @(posedge pclk) begin
        if (presetn && prev_cmd === CMD_DESEL && cmd !== CMD_DESEL) begin
            if (q.size() == 0) chk("unexpected command", 0, {cmd, mem_bank, memory_address_bus});
            else begin
                en = q.pop_front();
                chk("command", en[37:19], {cmd, mem_bank, memory_address_bus} & en[18:0]);
            end
        end
        prev_cmd = cmd;
    end

    initial begin
        #(40 * 40000);
        mismatches++;
        conclude();
    end

    initial begin
        logic [31:0] r;
        logic e, f, dl;
        logic [15:0] h;
        logic [3:0] d;
        logic [2:0] s;
        logic [7:0] orv, andn;
        logic [2:0] mtab [7];
        int t;
        mtab = '{SPM_NOP, SPM_PRE_ALL, SPM_MRS, SPM_MRS, SPM_EMRS, SPM_CBR, SPM_NORMAL};
        void'($urandom(549));
        repeat (12) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        rd(MCTL_OFFSET, MCTL_RESET, "mode reset");
        rd(CCTL_OFFSET, {24'h0, CCTL_RESET}, "clock reset");
        apb(0, 12'h090, 0, r, e);
        chk("unmapped error", 1, e);
        $display("test reset done");
        // Each non-reserved special mode, mode set twice; index 3 is the single-channel mode set
        for (int k = 0; k < 7; k++) begin
            s = mtab[k];
            dl = (k != 3);
            wr(MCTL_OFFSET, mc(0, dl, RATE_OFF, s));
            rd(MCTL_OFFSET, mc(0, dl, RATE_OFF, s), "mode control");
            h = 16'($urandom);
            case (s)
                SPM_NOP: note({CMD_NOP, 15'h0}, {4'hf, 15'h0});
                SPM_PRE_ALL: note({CMD_PRE, 2'h0, ADDR_PRE_ALL}, {4'hf, 2'h0, ADDR_PRE_ALL});
                SPM_MRS: note({CMD_MRS, BANK_MRS, dl ? {h[15:14], 1'b0, h[13:5], 1'b0}
                               : {h[14:13], 1'b0, h[12:5], 2'b11}}, '1);
                SPM_EMRS: note({CMD_MRS, BANK_EMRS, h[15:3]}, '1);
                SPM_CBR: note({CMD_REF, 15'h0}, {4'hf, 15'h0});
                default: ;
            endcase
            slow <= k[0];
            host(h, f);
            chk("forwarded", 32'(s == SPM_NORMAL), f);
        end
        $display("test special modes done");
        // Gated pairs stay still; others keep running whatever the frequency bit
        for (int j = 0; j < 4; j++) begin
            d = (j == 0) ? 4'h0 : (j == 3) ? 4'hf : 4'($urandom);
            f = 1'($urandom);
            wr(CCTL_OFFSET, {24'h0, f, 3'h0, d});
            rd(CCTL_OFFSET, {24'h0, f, 3'h0, d}, "clock control");
            repeat (3) @(posedge pclk);
            orv = '0;
            andn = '1;
            repeat (40) begin
                @(posedge pclk);
                orv |= {ck_ch1, ck_ch0};
                andn &= {ck_ch1_n, ck_ch0_n};
            end
            chk("true clocks", {~d, ~d}, orv);
            chk("complement clocks", {d, d}, andn);
        end
        $display("test clock gate done");
        // Fast rate with init pending must stay silent, then refresh once set
        wr(MCTL_OFFSET, mc(0, 1, RATE_FAST, SPM_NORMAL));
        repeat (1200) @(posedge pclk);
        note({CMD_REF, 15'h0}, {4'hf, 15'h0});
        wr(MCTL_OFFSET, mc(1, 1, RATE_FAST, SPM_NORMAL));
        for (int n = 0; n < 1500 && q.size() != 0; n++) @(posedge pclk);
        wr(MCTL_OFFSET, mc(1, 1, RATE_OFF, SPM_NORMAL));
        chk("refresh pending", 0, q.size());
        // Low frequency bit: 7.8 us is 780 memory clocks, 8 pclk each in this bench
        wr(CCTL_OFFSET, 32'h0000_0000);
        note({CMD_REF, 15'h0}, {4'hf, 15'h0});
        wr(MCTL_OFFSET, mc(1, 1, RATE_7U8, SPM_NORMAL));
        for (t = 0; t < 7000 && q.size() != 0; t++) @(posedge pclk);
        wr(MCTL_OFFSET, mc(1, 1, RATE_OFF, SPM_NORMAL));
        chk("refresh interval", 1, 32'(t >= 8 * 778 && t <= 8 * 782));
        $display("test refresh done");
        conclude();
    end
endmodule

// ---- src/dimcg_pkg.sv ----
// Constants for the DDR init-mode selector and clock gate block.
// Assumes a single APB clock domain; memory clock arrives as a plain input.
package dimcg_pkg;
    // Register byte offsets
    localparam logic [11:0] MCTL_OFFSET     = 12'h07c;
    localparam logic [11:0] CCTL_OFFSET     = 12'h08c;
    // Reset values
    localparam logic [31:0] MCTL_RESET      = 32'h0044_0009;
    localparam logic [7:0]  CCTL_RESET      = 8'h80;
    // Mode control field positions
    localparam int          INIT_DONE_BIT   = 29;
    localparam int          DUAL_PATH_BIT   = 22;
    localparam int          INTEG_LSB       = 20;
    localparam int          GRAN_LSB        = 18;
    localparam int          CPC_BIT         = 16;
    localparam int          RATE_LSB        = 8;
    localparam int          SPM_LSB         = 4;
    // Constant read-back of the low reserved nibble
    localparam logic [3:0]  MCTL_LOW_RSV    = 4'h9;
    // Granularity codes, follow the channel count
    localparam logic [1:0]  GRAN_SINGLE     = 2'h0;
    localparam logic [1:0]  GRAN_DUAL       = 2'h1;
    // Clock control field positions
    localparam int          FREQ_BIT        = 7;
    // Special mode codes
    localparam logic [2:0]  SPM_RSV0        = 3'h0;
    localparam logic [2:0]  SPM_NOP         = 3'h1;
    localparam logic [2:0]  SPM_PRE_ALL     = 3'h2;
    localparam logic [2:0]  SPM_MRS         = 3'h3;
    localparam logic [2:0]  SPM_EMRS        = 3'h4;
    localparam logic [2:0]  SPM_RSV5        = 3'h5;
    localparam logic [2:0]  SPM_CBR         = 3'h6;
    localparam logic [2:0]  SPM_NORMAL      = 3'h7;
    // Refresh rate codes
    localparam logic [2:0]  RATE_OFF        = 3'h0;
    localparam logic [2:0]  RATE_15U6       = 3'h1;
    localparam logic [2:0]  RATE_7U8        = 3'h2;
    localparam logic [2:0]  RATE_64U        = 3'h3;
    localparam logic [2:0]  RATE_FAST       = 3'h7;
    // Command codes {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0]  CMD_DESEL       = 4'hf;
    localparam logic [3:0]  CMD_NOP         = 4'h7;
    localparam logic [3:0]  CMD_PRE         = 4'h2;
    localparam logic [3:0]  CMD_MRS         = 4'h0;
    localparam logic [3:0]  CMD_REF         = 4'h1;
    localparam logic [1:0]  BANK_MRS        = 2'h0;
    localparam logic [1:0]  BANK_EMRS       = 2'h1;
    localparam logic [12:0] ADDR_PRE_ALL    = 13'h0400;
    // Refresh intervals in tenths of a microsecond, clock rates in MHz, fast interval in memory clocks
    localparam int          MHZ_LO          = 100;
    localparam int          MHZ_HI          = 133;
    localparam int          T15U6_TENTHS    = 156;
    localparam int          T7U8_TENTHS     = 78;
    localparam int          T64U_TENTHS     = 640;
    localparam int          FAST_CLOCKS     = 64;
    // Memory clocks per interval, every count rounds down
    localparam logic [13:0] R156_LO         = 14'((T15U6_TENTHS * MHZ_LO) / 10);
    localparam logic [13:0] R156_HI         = 14'((T15U6_TENTHS * MHZ_HI) / 10);
    localparam logic [13:0] R78_LO          = 14'((T7U8_TENTHS * MHZ_LO) / 10);
    localparam logic [13:0] R78_HI          = 14'((T7U8_TENTHS * MHZ_HI) / 10);
    localparam logic [13:0] R640_LO         = 14'((T64U_TENTHS * MHZ_LO) / 10);
    localparam logic [13:0] R640_HI         = 14'((T64U_TENTHS * MHZ_HI) / 10);
    localparam logic [13:0] RFAST           = 14'(FAST_CLOCKS);
    // Command sequencer states
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_CMD  = 4'b0010,
        ST_NORM = 4'b0100,
        ST_REF  = 4'b1000
    } dimcg_state_t;
endpackage

// ---- src/dimcg_sync.sv ----
// Three-stage synchroniser with glitch filter and rising-edge pulse.
// Assumes din is asynchronous to clk and slower than clk by a few times.
`timescale 1ns/1ps
module dimcg_sync (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic din,
    output logic      level,
    output logic      rise
);
    logic s1;
    logic s2;
    logic s3;
    wire  agree      = (s2 == s3);
    wire  next_level = agree ? s3 : level;

    // Stage one feeds only stage two, so metastability stays contained
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
        end else begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // Level moves only once two late stages agree
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            level <= 1'b0;
            rise  <= 1'b0;
        end else begin
            level <= next_level;
            rise  <= next_level & ~level;
        end
    end
endmodule

// ---- src/dimcg_top.sv ----
// DDR power-up mode selector, refresh timer and DIMM clock gate with APB registers.
// Assumes the memory clock is an outside input, sampled here; host requests are same-clock.
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
module dimcg_top
    import dimcg_pkg::*;
#(
    parameter logic [13:0] REF64_LO = R640_LO,
    parameter logic [13:0] REF64_HI = R640_HI
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        host_req,
    input  wire logic [15:0] host_address_lines,
    output logic             host_ack,
    output logic             normal_req,
    input  wire logic        normal_done,
    input  wire logic        ddr_clk_in,
    output logic             mem_cs_n,
    output logic             mem_ras_n,
    output logic             mem_cas_n,
    output logic             mem_we_n,
    output logic      [1:0]  mem_bank,
    output logic      [12:0] memory_address_bus,
    output logic      [3:0]  ck_ch0,
    output logic      [3:0]  ck_ch0_n,
    output logic      [3:0]  ck_ch1,
    output logic      [3:0]  ck_ch1_n
);
    // Register fields
    logic         init_done;
    logic         dual_path_select;
    logic [1:0]   integ_mode;
    logic         cmd_per_clk;
    logic [2:0]   refresh_rate_select;
    logic [2:0]   special_mode_select;
    logic         freq_hi;
    logic [3:0]   ck_off;
    // Sequencer and timer state
    dimcg_state_t st;
    dimcg_state_t next_st;
    logic         ref_pending;
    logic [13:0]  ref_count;
    logic         link_level;
    logic         link_rise;

    // Memory clock sampled into this domain
    dimcg_sync u_link_sync (
        .clk   (pclk),
        .rst_n (presetn),
        .din   (ddr_clk_in),
        .level (link_level),
        .rise  (link_rise)
    );

    // Command code for each special mode
    function automatic logic [3:0] mode_cmd(input logic [2:0] m);
        case (m)
            SPM_NOP:     mode_cmd = CMD_NOP;
            SPM_PRE_ALL: mode_cmd = CMD_PRE;
            SPM_MRS:     mode_cmd = CMD_MRS;
            SPM_EMRS:    mode_cmd = CMD_MRS;
            SPM_CBR:     mode_cmd = CMD_REF;
            default:     mode_cmd = CMD_DESEL;
        endcase
    endfunction

    // APB decode; slave answers in the first access cycle
    wire        apb_setup  = psel & ~penable;
    wire        apb_write  = psel & penable & pready & pwrite;
    wire        hit_mctl   = (paddr == MCTL_OFFSET);
    wire        hit_cctl   = (paddr == CCTL_OFFSET);
    wire        wr_mctl    = apb_write & hit_mctl & ~pslverr;
    wire        wr_cctl    = apb_write & hit_cctl & ~pslverr;
    wire [1:0]  gran       = dual_path_select ? GRAN_DUAL : GRAN_SINGLE;
    wire [31:0] mctl_rd    = {2'h0, init_done, 6'h00, dual_path_select, integ_mode, gran, 1'b0,
                              cmd_per_clk, 5'h00, refresh_rate_select, 1'b0, special_mode_select,
                              MCTL_LOW_RSV};
    wire [31:0] cctl_rd    = {24'h000000, freq_hi, 3'h0, ck_off};
    wire [31:0] next_rdata = hit_mctl ? mctl_rd : (hit_cctl ? cctl_rd : 32'h0000_0000);

    // Bus answer flops: ready one cycle after setup, error for unmapped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= apb_setup;
            pslverr <= apb_setup & ~(hit_mctl | hit_cctl);
            prdata  <= apb_setup ? next_rdata : 32'h0000_0000;
        end
    end

    // Mode control register; reserved and read-only bits are not stored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            init_done           <= MCTL_RESET[INIT_DONE_BIT];
            dual_path_select    <= MCTL_RESET[DUAL_PATH_BIT];
            integ_mode          <= MCTL_RESET[INTEG_LSB +: 2];
            cmd_per_clk         <= MCTL_RESET[CPC_BIT];
            refresh_rate_select <= MCTL_RESET[RATE_LSB +: 3];
            special_mode_select <= MCTL_RESET[SPM_LSB +: 3];
        end else if (wr_mctl) begin
            init_done           <= pwdata[INIT_DONE_BIT];
            dual_path_select    <= pwdata[DUAL_PATH_BIT];
            integ_mode          <= pwdata[INTEG_LSB +: 2];
            cmd_per_clk         <= pwdata[CPC_BIT];
            refresh_rate_select <= pwdata[RATE_LSB +: 3];
            special_mode_select <= pwdata[SPM_LSB +: 3];
        end
    end

    // Clock control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            freq_hi <= CCTL_RESET[FREQ_BIT];
            ck_off  <= CCTL_RESET[3:0];
        end else if (wr_cctl) begin
            freq_hi <= pwdata[FREQ_BIT];
            ck_off  <= pwdata[3:0];
        end
    end

    // Gated clock pairs; both channels share the disable bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ck_ch0   <= 4'h0;
            ck_ch0_n <= 4'hf;
            ck_ch1   <= 4'h0;
            ck_ch1_n <= 4'hf;
        end else begin
            ck_ch0   <= {4{link_level}} & ~ck_off;
            ck_ch0_n <= ~{4{link_level}} | ck_off;
            ck_ch1   <= {4{link_level}} & ~ck_off;
            ck_ch1_n <= ~{4{link_level}} | ck_off;
        end
    end

    // Interval in memory clocks; the frequency bit feeds only this lookup
    wire [13:0] lim_156 = freq_hi ? R156_HI : R156_LO;
    wire [13:0] lim_78  = freq_hi ? R78_HI : R78_LO;
    wire [13:0] lim_64  = freq_hi ? REF64_HI : REF64_LO;
    wire [13:0] ref_limit = (refresh_rate_select == RATE_15U6) ? lim_156 :
                            (refresh_rate_select == RATE_7U8)  ? lim_78 :
                            (refresh_rate_select == RATE_64U)  ? lim_64 :
                            (refresh_rate_select == RATE_FAST) ? RFAST : 14'h0000;
    // Reserved rate codes leave refresh off
    wire        rate_ok    = (ref_limit != 14'h0000);
    wire        ref_enable = init_done & rate_ok;
    wire        ref_tick   = ref_enable & link_rise & (ref_count >= ref_limit - 14'h0001);

    // Refresh timer counts memory clock edges
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_count <= 14'h0000;
        end else if (!ref_enable) begin
            ref_count <= 14'h0000;
        end else if (link_rise) begin
            ref_count <= ref_tick ? 14'h0000 : ref_count + 14'h0001;
        end
    end

    // Pending refresh: a new tick wins over the service clear
    wire take_ref  = (st == ST_IDLE) & ref_pending;
    wire take_host = (st == ST_IDLE) & ~ref_pending & host_req & ~host_ack; // Request still up in ack cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_pending <= 1'b0;
        end else if (ref_tick) begin
            ref_pending <= 1'b1;
        end else if (take_ref | ~ref_enable) begin
            ref_pending <= 1'b0;
        end
    end

    // Special-mode address mapping
    wire        is_normal   = (special_mode_select == SPM_NORMAL) | (special_mode_select == SPM_RSV0) |
                              (special_mode_select == SPM_RSV5);
    wire [12:0] mrs_dual    = {host_address_lines[15:14], 1'b0, host_address_lines[13:5], 1'b0};
    wire [12:0] mrs_single  = {host_address_lines[14:13], 1'b0, host_address_lines[12:5], 2'b11};
    wire [12:0] mrs_addr    = dual_path_select ? mrs_dual : mrs_single;
    wire [12:0] emrs_addr   = host_address_lines[15:3];
    wire [12:0] host_ma     = (special_mode_select == SPM_MRS)     ? mrs_addr :
                              (special_mode_select == SPM_EMRS)    ? emrs_addr :
                              (special_mode_select == SPM_PRE_ALL) ? ADDR_PRE_ALL : 13'h0000;
    wire [1:0]  host_bank   = (special_mode_select == SPM_EMRS) ? BANK_EMRS : BANK_MRS;
    wire [3:0]  host_cmd    = mode_cmd(special_mode_select);

    // Sequencer next state
    always_comb begin
        next_st = st;
        case (st)
            ST_IDLE: begin
                if (take_ref) begin
                    next_st = ST_REF;
                end else if (take_host) begin
                    next_st = is_normal ? ST_NORM : ST_CMD;
                end
            end
            ST_CMD:  next_st = link_rise ? ST_IDLE : ST_CMD;
            ST_REF:  next_st = link_rise ? ST_IDLE : ST_REF;
            ST_NORM: next_st = normal_done ? ST_IDLE : ST_NORM;
            default: next_st = ST_IDLE;
        endcase
    end

    // Commands are held until the next synchronised memory clock rise pulse, which can come from an edge before the command
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= ST_IDLE;
        end else begin
            st <= next_st;
        end
    end

    // Command, address and handshake outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} <= CMD_DESEL;
            mem_bank           <= 2'h0;
            memory_address_bus <= 13'h0000;
            host_ack           <= 1'b0;
            normal_req         <= 1'b0;
        end else begin
            host_ack <= 1'b0;
            if (take_ref) begin
                {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} <= CMD_REF;
                mem_bank           <= 2'h0;
                memory_address_bus <= 13'h0000;
            end else if (take_host & ~is_normal) begin
                {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} <= host_cmd;
                mem_bank           <= host_bank;
                memory_address_bus <= host_ma;
            end else if (take_host) begin
                normal_req <= 1'b1;
            end else if (((st == ST_CMD) | (st == ST_REF)) & link_rise) begin
                {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} <= CMD_DESEL;
                mem_bank           <= 2'h0;
                memory_address_bus <= 13'h0000;
                host_ack           <= (st == ST_CMD);
            end else if ((st == ST_NORM) & normal_done) begin
                normal_req <= 1'b0;
                host_ack   <= 1'b1;
            end
        end
    end

    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    wire [3:0] cmd_out = {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n};

    chk_nop_issue: assert property (
        take_host && special_mode_select == SPM_NOP |=> cmd_out == CMD_NOP && st == ST_CMD)
        else $error("NOP mode did not issue NOP");
    chk_pre_all_issue: assert property (
        take_host && special_mode_select == SPM_PRE_ALL |=> cmd_out == CMD_PRE && memory_address_bus[10])
        else $error("precharge mode did not issue all-bank precharge");
    chk_mrs_dual_map: assert property (
        take_host && special_mode_select == SPM_MRS && dual_path_select
        |=> cmd_out == CMD_MRS && memory_address_bus == {$past(host_address_lines[15:14]), 1'b0,
            $past(host_address_lines[13:5]), 1'b0})
        else $error("dual mode set address wrong");
    chk_mrs_single_map: assert property (
        take_host && special_mode_select == SPM_MRS && !dual_path_select
        |=> memory_address_bus == {$past(host_address_lines[14:13]), 1'b0,
            $past(host_address_lines[12:5]), 2'b11})
        else $error("single mode set address wrong");
    chk_emrs_map: assert property (
        take_host && special_mode_select == SPM_EMRS
        |=> cmd_out == CMD_MRS && mem_bank == BANK_EMRS && memory_address_bus == $past(host_address_lines[15:3]))
        else $error("extended mode set wrong");
    chk_cbr_issue: assert property (
        take_host && special_mode_select == SPM_CBR |=> cmd_out == CMD_REF)
        else $error("CBR mode did not issue refresh");
    chk_normal_pass: assert property (
        take_host && special_mode_select == SPM_NORMAL |=> normal_req && cmd_out == CMD_DESEL)
        else $error("normal mode not forwarded");
    chk_no_early_ref: assert property (
        !init_done && $past(!init_done) && st == ST_IDLE |=> st != ST_REF)
        else $error("refresh before init done");
    chk_rate_limit: assert property (
        refresh_rate_select == RATE_7U8 |-> ref_limit == 14'((T7U8_TENTHS * (freq_hi ? MHZ_HI : MHZ_LO)) / 10))
        else $error("refresh count not from frequency bit");
    chk_ck_gated: assert property (
        ck_off == $past(ck_off) |-> (ck_ch0 & ck_off) == 4'h0 && (ck_ch0_n & ck_off) == ck_off
            && ck_ch1 == ck_ch0 && ck_ch1_n == ck_ch0_n)
        else $error("disabled clock pair not parked");
    chk_special_ack: assert property (
        st == ST_CMD && link_rise |=> host_ack && st == ST_IDLE ##1 !host_ack)
        else $error("special access not acknowledged");

    cov_mrs_dual:   cover property (take_host && special_mode_select == SPM_MRS && dual_path_select);
    cov_refresh:    cover property (st == ST_REF && link_rise);
    cov_normal:     cover property (st == ST_NORM && normal_done);
    cov_bus_error:  cover property (pready && pslverr);
endmodule
